// [src/gpio23_pkg.sv]
// register map, reset values and helpers shared by the two-port gpio block
`default_nettype none
package gpio23_pkg;

   // register indices as printed; the byte address is four times the index
   localparam logic [31:0] IDX_P8_DATA = 32'hFFFFF004;
   localparam logic [31:0] IDX_P6_DATA = 32'hFFFFF006;
   localparam logic [31:0] IDX_P8_DIR = 32'hFFFFF024;
   localparam logic [31:0] IDX_P6_DIR = 32'hFFFFF026;
   localparam logic [31:0] IDX_P8_PU = 32'hFFFFF084;
   localparam logic [31:0] IDX_P6_PU = 32'hFFFFF086;

   // address bits decoded; the top one selects the single-bit window
   localparam int ADDR_W = 13;
   localparam int BIT_WIN_POS = 12;

   // reset values
   localparam logic [7:0] RST_P8_DATA = 8'h00;
   localparam logic [7:0] RST_P8_DIR = 8'hFF;
   localparam logic [7:0] RST_P8_PU = 8'h00;
   localparam logic [7:0] RST_P6_DATA = 8'h00;
   localparam logic [7:0] RST_P6_DIR = 8'h3F;
   localparam logic [7:0] RST_P6_PU = 8'h00;

   // pin counts of the two ports
   localparam int P8_W = 8;
   localparam int P6_W = 6;

   // single-bit command: bits 2..0 pick the bit, bit 3 is its new value
   localparam int BCMD_VAL_POS = 3;

   // positions in the register hit vector
   localparam int H_D8 = 0;
   localparam int H_D6 = 1;
   localparam int H_M8 = 2;
   localparam int H_M6 = 3;
   localparam int H_U8 = 4;
   localparam int H_U6 = 5;
   localparam int H_N = 6;

   // bus response code
   localparam logic HRESP_OKAY = 1'b0;

   // bus slave phases
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_WRITE = 4'h2,
      ST_READ = 4'h4,
      ST_RDONE = 4'h8
   } bus_state_t;

   // word address bits [11:2] of a register given its index
   function automatic logic hits(input logic [9:0] waddr,
                                 input logic [31:0] idx);
      return waddr == idx[9:0];
   endfunction

   // byte write or single-bit write of one register
   function automatic logic [7:0] apply_write(input logic [7:0] old,
                                              input logic [7:0] wbyte,
                                              input logic bit_mode);
      logic [7:0] res;
      res = wbyte;
      if (bit_mode)
      begin
         res = old;
         res[wbyte[2:0]] = wbyte[BCMD_VAL_POS];
      end
      return res;
   endfunction

   // pin level for inputs, output latch for outputs
   function automatic logic [7:0] read_view(input logic [7:0] latch,
                                            input logic [7:0] dir,
                                            input logic [7:0] pin);
      return (dir & pin) | (~dir & latch);
   endfunction

endpackage
`default_nettype wire

// [src/gpio_bank_if.sv]
// write command and register state of one gpio bank
`timescale 1ns/1ps
`default_nettype none
interface gpio_bank_if #(parameter int WIDTH = 8);
   logic wr_data;
   logic wr_dir;
   logic wr_pu;
   logic bit_mode;
   logic [7:0] wbyte;
   logic [WIDTH-1:0] latch;
   logic [WIDTH-1:0] dir;
   logic [WIDTH-1:0] pu;
   modport ctrl (output wr_data, wr_dir, wr_pu, bit_mode, wbyte,
                 input latch, dir, pu);
   modport bank (input wr_data, wr_dir, wr_pu, bit_mode, wbyte,
                 output latch, dir, pu);
endinterface
`default_nettype wire

// [src/gpio_bank.sv]
// data latch, direction and pull-up registers of one port
`timescale 1ns/1ps
`default_nettype none
module gpio_bank #(
   parameter int WIDTH = 8,
   parameter logic [7:0] DATA_RST = 8'h00,
   parameter logic [7:0] DIR_RST = 8'hFF,
   parameter logic [7:0] PU_RST = 8'h00
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register access
   gpio_bank_if.bank bus
);
   logic [7:0] latch8;
   logic [7:0] dir8;
   logic [7:0] pu8;
   logic [7:0] latch_next;
   logic [7:0] dir_next;
   logic [7:0] pu_next;

   // widen to a byte so one write helper serves both ports
   assign latch8 = 8'(bus.latch);
   assign dir8 = 8'(bus.dir);
   assign pu8 = 8'(bus.pu);

   // next byte of each register; only the low WIDTH bits get stored
   assign latch_next = gpio23_pkg::apply_write(latch8, bus.wbyte,
                                               bus.bit_mode);
   assign dir_next = gpio23_pkg::apply_write(dir8, bus.wbyte,
                                             bus.bit_mode);
   assign pu_next = gpio23_pkg::apply_write(pu8, bus.wbyte,
                                            bus.bit_mode);

   // output latch; bits above WIDTH are simply not stored
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         bus.latch <= DATA_RST[WIDTH-1:0];
      else if (bus.wr_data)
         bus.latch <= latch_next[WIDTH-1:0];
   end

   // direction, one bit per pin, 1 means input
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         bus.dir <= DIR_RST[WIDTH-1:0];
      else if (bus.wr_dir)
         bus.dir <= dir_next[WIDTH-1:0];
   end

   // pull-up enables
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         bus.pu <= PU_RST[WIDTH-1:0];
      else if (bus.wr_pu)
         bus.pu <= pu_next[WIDTH-1:0];
   end
endmodule // gpio_bank
`default_nettype wire

// [src/pin_tap.sv]
// registered copy of pin levels handed to the timer inputs
`timescale 1ns/1ps
`default_nettype none
module pin_tap #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // pins in, timer taps out
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] tap_o
);
   // one flop keeps timer inputs glitch free on the core clock
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         tap_o <= '0;
      else
         tap_o <= pin_i;
   end
endmodule // pin_tap
`default_nettype wire

// [src/gpio_ports.sv]
// two gpio ports with an ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none

module gpio_ports (
   // clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   // ahb-lite slave
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   output logic [31:0] HRDATA_O,
   // eight-bit port pins
   input wire logic [7:0] PORT8_PIN_I,
   output logic [7:0] PORT8_PIN_O,
   output logic [7:0] PORT8_OE_N_O,
   output logic [7:0] PORT8_PULLUP_O,
   // six-bit port pins
   input wire logic [5:0] PORT6_PIN_I,
   output logic [5:0] PORT6_PIN_O,
   output logic [5:0] PORT6_OE_N_O,
   output logic [5:0] PORT6_PULLUP_O,
   // timer input taps of the eight-bit port
   output logic [5:0] TIMER_G_CAPTURE_IN_O,
   output logic EIGHT_BIT_TIMER_A_IO_O,
   output logic EIGHT_BIT_TIMER_B_IO_O,
   // timer input taps of the six-bit port
   output logic [1:0] TIMER_C_CAPTURE_OR_OUTPUT_O,
   output logic [1:0] TIMER_C_CAPTURE_ONLY_O
);
   gpio23_pkg::bus_state_t state_reg;
   gpio23_pkg::bus_state_t state_next;
   logic accept;
   logic [gpio23_pkg::ADDR_W-1:0] addr_reg;
   logic [gpio23_pkg::H_N-1:0] hit;
   logic bit_mode;
   logic wr_phase;
   logic [7:0] rd_byte;
   logic [31:0] hrdata_reg;
   logic [7:0] view8;
   logic [7:0] view6;
   logic [7:0] tap8;
   logic [5:0] tap6;

   gpio_bank_if #(.WIDTH(gpio23_pkg::P8_W)) p8_if ();
   gpio_bank_if #(.WIDTH(gpio23_pkg::P6_W)) p6_if ();

   // address phase is taken only while the bus is ready
   assign accept = HSEL_I && HTRANS_I[1] && HREADY_I;

   // capture the decoded part of the address for the data phase
   always_ff @(posedge CORE_CLK_I or posedge RST_I)
   begin
      if (RST_I)
         addr_reg <= '0;
      else if (accept)
         addr_reg <= HADDR_I[gpio23_pkg::ADDR_W-1:0];
   end

   // phase sequencer: writes finish at once, reads take one wait state
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         gpio23_pkg::ST_IDLE,
         gpio23_pkg::ST_WRITE,
         gpio23_pkg::ST_RDONE:
         begin
            if (accept && HWRITE_I)
               state_next = gpio23_pkg::ST_WRITE;
            else if (accept)
               state_next = gpio23_pkg::ST_READ;
            else
               state_next = gpio23_pkg::ST_IDLE;
         end
         gpio23_pkg::ST_READ:
            state_next = gpio23_pkg::ST_RDONE;
         default:
            state_next = gpio23_pkg::ST_IDLE;
      endcase
   end

   // phase register
   always_ff @(posedge CORE_CLK_I or posedge RST_I)
   begin
      if (RST_I)
         state_reg <= gpio23_pkg::ST_IDLE;
      else
         state_reg <= state_next;
   end

   // register decode; unmapped words read zero and drop writes
   always_comb
   begin
      hit = '0;
      hit[gpio23_pkg::H_D8] = gpio23_pkg::hits(addr_reg[11:2],
                                               gpio23_pkg::IDX_P8_DATA);
      hit[gpio23_pkg::H_D6] = gpio23_pkg::hits(addr_reg[11:2],
                                               gpio23_pkg::IDX_P6_DATA);
      hit[gpio23_pkg::H_M8] = gpio23_pkg::hits(addr_reg[11:2],
                                               gpio23_pkg::IDX_P8_DIR);
      hit[gpio23_pkg::H_M6] = gpio23_pkg::hits(addr_reg[11:2],
                                               gpio23_pkg::IDX_P6_DIR);
      hit[gpio23_pkg::H_U8] = gpio23_pkg::hits(addr_reg[11:2],
                                               gpio23_pkg::IDX_P8_PU);
      hit[gpio23_pkg::H_U6] = gpio23_pkg::hits(addr_reg[11:2],
                                               gpio23_pkg::IDX_P6_PU);
   end

   // the upper address window turns a write into a single-bit update
   assign bit_mode = addr_reg[gpio23_pkg::BIT_WIN_POS];
   assign wr_phase = state_reg == gpio23_pkg::ST_WRITE;

   // write strobes into the eight-bit bank
   assign p8_if.wr_data = wr_phase && hit[gpio23_pkg::H_D8];
   assign p8_if.wr_dir = wr_phase && hit[gpio23_pkg::H_M8];
   assign p8_if.wr_pu = wr_phase && hit[gpio23_pkg::H_U8];
   assign p8_if.bit_mode = bit_mode;
   assign p8_if.wbyte = HWDATA_I[7:0];

   // write strobes into the six-bit bank
   assign p6_if.wr_data = wr_phase && hit[gpio23_pkg::H_D6];
   assign p6_if.wr_dir = wr_phase && hit[gpio23_pkg::H_M6];
   assign p6_if.wr_pu = wr_phase && hit[gpio23_pkg::H_U6];
   assign p6_if.bit_mode = bit_mode;
   assign p6_if.wbyte = HWDATA_I[7:0];

   // eight-bit port registers
   gpio_bank #(
      .WIDTH(gpio23_pkg::P8_W),
      .DATA_RST(gpio23_pkg::RST_P8_DATA),
      .DIR_RST(gpio23_pkg::RST_P8_DIR),
      .PU_RST(gpio23_pkg::RST_P8_PU)
   ) u_bank8 (
      .clk_i(CORE_CLK_I),
      .rst_i(RST_I),
      .bus(p8_if.bank)
   );

   // six-bit port registers
   gpio_bank #(
      .WIDTH(gpio23_pkg::P6_W),
      .DATA_RST(gpio23_pkg::RST_P6_DATA),
      .DIR_RST(gpio23_pkg::RST_P6_DIR),
      .PU_RST(gpio23_pkg::RST_P6_PU)
   ) u_bank6 (
      .clk_i(CORE_CLK_I),
      .rst_i(RST_I),
      .bus(p6_if.bank)
   );

   // pins: a direction bit of 0 turns the output buffer on
   assign PORT8_PIN_O = p8_if.latch;
   assign PORT8_OE_N_O = p8_if.dir;
   assign PORT8_PULLUP_O = p8_if.pu;
   assign PORT6_PIN_O = p6_if.latch;
   assign PORT6_OE_N_O = p6_if.dir;
   assign PORT6_PULLUP_O = p6_if.pu;

   // data read view per pin
   assign view8 = gpio23_pkg::read_view(p8_if.latch, p8_if.dir,
                                        PORT8_PIN_I);
   assign view6 = gpio23_pkg::read_view(8'(p6_if.latch), 8'(p6_if.dir),
                                        8'(PORT6_PIN_I));

   // read mux; six-bit registers pad their top two bits with zero
   always_comb
   begin
      rd_byte = 8'h00;
      if (hit[gpio23_pkg::H_D8])
         rd_byte = view8;
      if (hit[gpio23_pkg::H_D6])
         rd_byte = view6;
      if (hit[gpio23_pkg::H_M8])
         rd_byte = p8_if.dir;
      if (hit[gpio23_pkg::H_M6])
         rd_byte = 8'(p6_if.dir);
      if (hit[gpio23_pkg::H_U8])
         rd_byte = p8_if.pu;
      if (hit[gpio23_pkg::H_U6])
         rd_byte = 8'(p6_if.pu);
   end

   // read data is registered, which costs the one wait state
   always_ff @(posedge CORE_CLK_I or posedge RST_I)
   begin
      if (RST_I)
         hrdata_reg <= 32'h00000000;
      else if (state_reg == gpio23_pkg::ST_READ)
         hrdata_reg <= {24'h000000, rd_byte};
   end

   // bus answers; only the read data phase stalls
   assign HRDATA_O = hrdata_reg;
   assign HREADYOUT_O = state_reg != gpio23_pkg::ST_READ;
   assign HRESP_O = gpio23_pkg::HRESP_OKAY;

   // pin levels toward the timers; alternate outputs stay outside
   pin_tap #(.WIDTH(gpio23_pkg::P8_W)) u_tap8 (
      .clk_i(CORE_CLK_I),
      .rst_i(RST_I),
      .pin_i(PORT8_PIN_I),
      .tap_o(tap8)
   );
   pin_tap #(.WIDTH(gpio23_pkg::P6_W)) u_tap6 (
      .clk_i(CORE_CLK_I),
      .rst_i(RST_I),
      .pin_i(PORT6_PIN_I),
      .tap_o(tap6)
   );

   // eight-bit port sharing
   assign TIMER_G_CAPTURE_IN_O = tap8[5:0];
   assign EIGHT_BIT_TIMER_A_IO_O = tap8[6];
   assign EIGHT_BIT_TIMER_B_IO_O = tap8[7];

   // six-bit pin 0 carries the clock output chosen outside this block
   assign TIMER_C_CAPTURE_OR_OUTPUT_O = {tap6[3], tap6[1]};
   assign TIMER_C_CAPTURE_ONLY_O = {tap6[4], tap6[2]};

   // helper flags: has software written the register since reset
   logic dir8_written;
   logic data8_written;
   logic dir6_written;
   always_ff @(posedge CORE_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         dir8_written <= 1'b0;
         data8_written <= 1'b0;
         dir6_written <= 1'b0;
      end
      else
      begin
         dir8_written <= dir8_written | p8_if.wr_dir;
         data8_written <= data8_written | p8_if.wr_data;
         dir6_written <= dir6_written | p6_if.wr_dir;
      end
   end

   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (RST_I);

   // named steps of a bus transfer
   sequence s_read_data8;
      state_reg == gpio23_pkg::ST_READ && hit[gpio23_pkg::H_D8];
   endsequence
   sequence s_read_six;
      state_reg == gpio23_pkg::ST_READ &&
      (hit[gpio23_pkg::H_D6] || hit[gpio23_pkg::H_M6] ||
       hit[gpio23_pkg::H_U6]);
   endsequence
   sequence s_byte_wr_dir8;
      p8_if.wr_dir && !bit_mode;
   endsequence
   sequence s_bit_wr_dir8;
      p8_if.wr_dir && bit_mode;
   endsequence

   // direction only moves on its own write
   a_dir8_owned: assert property (
      !$stable(p8_if.dir) |-> $past(p8_if.wr_dir))
      else $error("eight-bit direction changed without a write");

   // a byte written to direction shows on the output enables next cycle
   a_dir_drives_oe: assert property (
      s_byte_wr_dir8 |=> PORT8_OE_N_O == $past(HWDATA_I[7:0]))
      else $error("output enable does not follow direction write");

   // all inputs until the first direction write
   a_dir8_reset: assert property (
      !dir8_written |-> PORT8_OE_N_O == gpio23_pkg::RST_P8_DIR)
      else $error("eight-bit port not all inputs after reset");

   // a pull-up byte write reaches the pull-up outputs
   a_pullup_follows: assert property (
      p8_if.wr_pu && !bit_mode |=>
      PORT8_PULLUP_O == $past(HWDATA_I[7:0]))
      else $error("pull-up enables do not follow write");

   // a single-bit write only touches the named bit
   a_bit_write_one: assert property (
      p6_if.wr_pu && bit_mode |=>
      ((8'(PORT6_PULLUP_O) ^ 8'($past(PORT6_PULLUP_O))) &
       ~(8'h01 << $past(HWDATA_I[2:0]))) == 8'h00)
      else $error("single-bit write touched another bit");

   // one pin changes direction alone
   a_pin_independent: assert property (
      s_bit_wr_dir8 |=>
      PORT8_OE_N_O[$past(HWDATA_I[2:0])] ==
      $past(HWDATA_I[gpio23_pkg::BCMD_VAL_POS]) &&
      $countones(PORT8_OE_N_O ^ $past(PORT8_OE_N_O)) <= 1)
      else $error("direction bit write not independent");

   // timer taps carry the pin levels one cycle late
   a_timer_taps: assert property (
      {EIGHT_BIT_TIMER_B_IO_O, EIGHT_BIT_TIMER_A_IO_O,
       TIMER_G_CAPTURE_IN_O} == $past(PORT8_PIN_I) &&
      TIMER_C_CAPTURE_ONLY_O == {$past(PORT6_PIN_I[4]),
                                 $past(PORT6_PIN_I[2])})
      else $error("timer tap does not follow pin");

   // six-bit registers read zero in bits 7 and 6
   a_six_upper_zero: assert property (
      s_read_six |=> HREADYOUT_O && HRDATA_O[31:6] == 26'h0000000)
      else $error("six-bit register read with upper bits set");

   // six-bit pins stay inputs until their direction is written
   a_dir6_reset: assert property (
      !dir6_written |-> PORT6_OE_N_O == gpio23_pkg::RST_P6_DIR[5:0])
      else $error("six-bit port not all inputs after reset");

   // eight-bit latch is zero until written
   a_data8_reset: assert property (
      !data8_written |-> PORT8_PIN_O == gpio23_pkg::RST_P8_DATA)
      else $error("eight-bit latch not zero after reset");

   // a data read returns pins for inputs and latch for outputs
   a_read_view: assert property (
      s_read_data8 |-> !HREADYOUT_O ##1
      (HREADYOUT_O && HRDATA_O == {24'h000000,
       ($past(PORT8_OE_N_O) & $past(PORT8_PIN_I)) |
       (~$past(PORT8_OE_N_O) & $past(PORT8_PIN_O))}))
      else $error("data read returned the wrong view");

endmodule // gpio_ports
`default_nettype wire

// [test/pin_model.sv]
// model of the pads and outside drivers seen by one port
`timescale 1ns/1ps
`default_nettype none
module pin_model #(
   parameter int W = 8
) (
   // clock
   input wire logic clk_i,
   // device side of the pads
   input wire logic [W-1:0] pin_o_i,
   input wire logic [W-1:0] oe_n_i,
   input wire logic [W-1:0] pullup_i,
   // outside driver set by the bench
   input wire logic [W-1:0] ext_en_i,
   input wire logic [W-1:0] ext_val_i,
   // resolved pad level
   output logic [W-1:0] pad_o
);
   logic [W-1:0] float_reg = '0;

   // an undriven pad without pull-up wanders, so nothing may rely on it
   always_ff @(posedge clk_i)
   begin
      float_reg <= ~float_reg;
   end

   // the device buffer wins, then the outside driver, then the pull-up
   always_comb
   begin
      for (int i = 0; i < W; i++)
      begin
         if (!oe_n_i[i])
            pad_o[i] = pin_o_i[i];
         else if (ext_en_i[i])
            pad_o[i] = ext_val_i[i];
         else if (pullup_i[i])
            pad_o[i] = 1'b1;
         else
            pad_o[i] = float_reg[i];
      end
   end
endmodule // pin_model
`default_nettype wire

// [test/tb_top.sv]
// register and pin tests of the two-port gpio block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         fails++; \
         $display("CHECK FAILED at %0t got %0h exp %0h", $time, got, exp); \
      end \
   end
module tb_top;
   logic clk, rst, hsel, hwrite, hready, hresp;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0] p8_in, p8_out, p8_oe_n, p8_pu, e8_en, e8_val;
   logic [5:0] p6_in, p6_out, p6_oe_n, p6_pu, e6_en, e6_val, tg;
   logic ta, tb;
   logic [1:0] tc_io, tc_cap;
   logic [31:0] regs [4];
   logic [7:0] wr_tab [4] = '{8'h5A, 8'hFF, 8'hA5, 8'hFF};
   logic [7:0] ex_tab [4] = '{8'h5A, 8'h3F, 8'hA5, 8'h3F};
   logic [7:0] pat [4] = '{8'h55, 8'hAA, 8'h81, 8'h7E};
   int fails = 0;
   int n_tests = 0;
   int cyc = 0;

   gpio_ports dut (.CORE_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel),
      .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
      .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
      .HREADYOUT_O(hready), .HRESP_O(hresp), .HRDATA_O(hrdata),
      .PORT8_PIN_I(p8_in), .PORT8_PIN_O(p8_out), .PORT8_OE_N_O(p8_oe_n),
      .PORT8_PULLUP_O(p8_pu), .PORT6_PIN_I(p6_in), .PORT6_PIN_O(p6_out),
      .PORT6_OE_N_O(p6_oe_n), .PORT6_PULLUP_O(p6_pu),
      .TIMER_G_CAPTURE_IN_O(tg), .EIGHT_BIT_TIMER_A_IO_O(ta),
      .EIGHT_BIT_TIMER_B_IO_O(tb), .TIMER_C_CAPTURE_OR_OUTPUT_O(tc_io),
      .TIMER_C_CAPTURE_ONLY_O(tc_cap));
   pin_model #(.W(8)) pads8 (.clk_i(clk), .pin_o_i(p8_out),
      .oe_n_i(p8_oe_n), .pullup_i(p8_pu), .ext_en_i(e8_en),
      .ext_val_i(e8_val), .pad_o(p8_in));
   pin_model #(.W(6)) pads6 (.clk_i(clk), .pin_o_i(p6_out),
      .oe_n_i(p6_oe_n), .pullup_i(p6_pu), .ext_en_i(e6_en),
      .ext_val_i(e6_val), .pad_o(p6_in));

   // 250 MHz core clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // byte address of a register: four times its printed index
   function automatic logic [31:0] ba(input logic [31:0] idx);
      return idx << 2;
   endfunction

   // one single transfer; hready and hrdata are sampled at rising edges
   task automatic xfer(input logic [31:0] a, input logic w,
                       input logic [7:0] wd, output logic [31:0] r);
      int n;
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'h2;
      n = 0;
      do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      n = 0;
      do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
      r = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [31:0] r;
      xfer(a, 1'b1, d, r);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
      logic [31:0] r;
      xfer(a, 1'b0, 8'h00, r);
      `CHK(r, {24'h0, e})
   endtask

   // verdict, reached from the main sequence or the hang guard
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fails++;
         final_report();
      end
   end

   // main sequence
   initial
   begin
      regs = '{ba(gpio23_pkg::IDX_P8_DIR), ba(gpio23_pkg::IDX_P6_DIR),
               ba(gpio23_pkg::IDX_P8_PU), ba(gpio23_pkg::IDX_P6_PU)};
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = 32'h0;
      e8_en = 8'hFF;
      e8_val = 8'h00;
      e6_en = 6'h3F;
      e6_val = 6'h00;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // reset values; outside pins held low so data reads give zero
      `CHK(p8_oe_n, 8'hFF)
      `CHK(p6_oe_n, 6'h3F)
      `CHK(p8_out, 8'h00)
      `CHK(p8_pu, 8'h00)
      `CHK(p6_pu, 6'h00)
      rd_chk(ba(gpio23_pkg::IDX_P8_DATA), 8'h00);
      rd_chk(ba(gpio23_pkg::IDX_P6_DATA), 8'h00);
      rd_chk(regs[0], 8'hFF);
      rd_chk(regs[1], 8'h3F);
      rd_chk(regs[2], 8'h00);
      rd_chk(regs[3], 8'h00);
      $display("test reset values done");
      // byte writes back to back, upper bits of six-bit registers dropped
      for (int i = 0; i < 4; i++)
         wr(regs[i], wr_tab[i]);
      for (int i = 0; i < 4; i++)
         rd_chk(regs[i], ex_tab[i]);
      @(negedge clk);
      `CHK(p8_oe_n, 8'h5A)
      `CHK(p6_oe_n, 6'h3F)
      `CHK(p8_pu, 8'hA5)
      `CHK(p6_pu, 6'h3F)
      @(posedge clk);
      $display("test byte access done");
      // single-bit writes turn pins to outputs one at a time
      wr(regs[0], 8'hFF);
      for (int b = 0; b < 8; b++)
      begin
         wr(regs[0] | 32'h1000, {5'h0, b[2:0]});
         @(negedge clk);
         `CHK(p8_oe_n, 8'hFF << (b + 1))
         @(posedge clk);
      end
      rd_chk(regs[0] | 32'h1000, 8'h00);
      wr(regs[3] | 32'h1000, 8'h02);
      wr(regs[3] | 32'h1000, 8'h0F);
      rd_chk(regs[3], 8'h3B);
      $display("test single-bit access done");
      // data reads mix latch and pin levels per direction bit
      e8_en <= 8'hF0;
      e8_val <= 8'hB0;
      wr(ba(gpio23_pkg::IDX_P8_DATA), 8'h3C);
      @(negedge clk);
      `CHK(p8_out, 8'h3C)
      @(posedge clk);
      rd_chk(ba(gpio23_pkg::IDX_P8_DATA), 8'h3C);
      wr(regs[0], 8'hF0);
      rd_chk(ba(gpio23_pkg::IDX_P8_DATA), 8'hBC);
      e8_en <= 8'h70;
      e8_val <= 8'h30;
      rd_chk(ba(gpio23_pkg::IDX_P8_DATA), 8'hBC);
      wr(regs[1], 8'h00);
      wr(ba(gpio23_pkg::IDX_P6_DATA), 8'hFF);
      @(negedge clk);
      `CHK(p6_out, 6'h3F)
      `CHK(p6_oe_n, 6'h00)
      @(posedge clk);
      rd_chk(ba(gpio23_pkg::IDX_P6_DATA), 8'h3F);
      $display("test data latch done");
      // timer taps follow the pins one edge late
      wr(regs[0], 8'hFF);
      wr(regs[1], 8'h3F);
      e8_en <= 8'hFF;
      e6_en <= 6'h3F;
      for (int i = 0; i < 4; i++)
      begin
         e8_val <= pat[i];
         e6_val <= pat[i][5:0];
         repeat (2) @(posedge clk);
         @(negedge clk);
         `CHK(tg, pat[i][5:0])
         `CHK({tb, ta}, pat[i][7:6])
         `CHK(tc_io, {pat[i][3], pat[i][1]})
         `CHK(tc_cap, {pat[i][4], pat[i][2]})
         @(posedge clk);
      end
      $display("test timer taps done");
      // unmapped word: write lost, read zero, response okay
      wr(32'h0000_0014, 8'h77);
      rd_chk(32'h0000_0014, 8'h00);
      `CHK(hresp, 1'b0)
      rd_chk(regs[0], 8'hFF);
      $display("test unmapped access done");
      final_report();
   end
endmodule // tb_top
`default_nettype wire
